// ==== core/tmr3_map.vh ====
// register map, field layout and mode codes for the timer 3 control block
`ifndef TMR3_MAP_VH
`define TMR3_MAP_VH
// register byte offsets
`define TMR3_OFS_CONTROL   12'h000
`define TMR3_OFS_PERIOD    12'h004
`define TMR3_OFS_PULSE     12'h008
`define TMR3_OFS_PARTNER   12'h00C
`define TMR3_OFS_STATUS    12'h010
`define TMR3_OFS_SYSCFG    12'h014
// control register fields
`define TMR3_CTL_MODE_LO   0
`define TMR3_CTL_MODE_HI   2
`define TMR3_CTL_START     3
`define TMR3_CTL_CLK_LO    4
`define TMR3_CTL_CLK_HI    6
`define TMR3_CTL_FF        7
// partner (unit 4) control bits held here
`define TMR3_PTN_MODE_LO   0
`define TMR3_PTN_MODE_HI   2
`define TMR3_PTN_START     3
`define TMR3_PTN_FF        7
// system configuration bits
`define TMR3_SYS_DIVSEL    0
`define TMR3_SYS_LOWSPEED  1
// status bits
`define TMR3_STS_REFUSED   18
// mode codes
`define TMR3_MODE_TIMER    3'b000
`define TMR3_MODE_PDO      3'b001
`define TMR3_MODE_PWM      3'b010
`define TMR3_MODE_CASCADE  3'b011
`define TMR3_PMODE_PWM16   3'b110
// clock select codes
`define TMR3_CLK_SLOWEST   3'b000
`define TMR3_CLK_FC        3'b110
`define TMR3_CLK_PIN       3'b111
// divider widths and taps
`define TMR3_DIV_W         11
`define TMR3_TAP_FC11      10
`define TMR3_TAP_FC7       6
`define TMR3_TAP_FC5       4
`define TMR3_TAP_FC3       2
`define TMR3_TAP_FC1       0
`define TMR3_TAP_FS3       2
// reset values
`define TMR3_RST_BYTE      8'h00
`define TMR3_RST_WORD      32'h0000_0000
`endif

// ==== core/tmr3_sync.v ====
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module tmr3_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output reg  dout
);
  reg stage1;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // tmr3_sync

// ==== core/tmr3_tick.v ====
// prescaler that turns a selected clock source into one-cycle count ticks
`timescale 1ns/10ps
`include "tmr3_map.vh"
module tmr3_tick
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire [2:0] clk_sel,
  input  wire       slow_src,
  input  wire       fc_tick,
  input  wire       fs_tick,
  input  wire       pin_rise,
  output reg        tick
);
  reg  [`TMR3_DIV_W-1:0] fc_div;
  reg  [`TMR3_DIV_W-1:0] fs_div;
  wire [`TMR3_DIV_W-1:0] fc_nxt;
  wire [`TMR3_DIV_W-1:0] fs_nxt;
  reg                    next_tick;

  assign fc_nxt = fc_div + {{(`TMR3_DIV_W-1){1'b0}}, 1'b1};
  assign fs_nxt = fs_div + {{(`TMR3_DIV_W-1){1'b0}}, 1'b1};

  // carry out of a divider stage: all lower bits set while incrementing
  function carry;
    input [`TMR3_DIV_W-1:0] cnt;
    input integer           tap;
    input                   inc;
    integer                 i;
    begin
      carry = inc;
      for (i = 0; i < `TMR3_DIV_W; i = i + 1)
        if (i <= tap)
          carry = carry & cnt[i];
    end
  endfunction

  always @*
  begin
    case (clk_sel)
      3'b000:  next_tick = slow_src ? carry(fs_div, `TMR3_TAP_FS3, fs_tick)
                                    : carry(fc_div, `TMR3_TAP_FC11, fc_tick);
      3'b001:  next_tick = carry(fc_div, `TMR3_TAP_FC7, fc_tick);
      3'b010:  next_tick = carry(fc_div, `TMR3_TAP_FC5, fc_tick);
      3'b011:  next_tick = carry(fc_div, `TMR3_TAP_FC3, fc_tick);
      3'b100:  next_tick = fs_tick;
      3'b101:  next_tick = carry(fc_div, `TMR3_TAP_FC1, fc_tick);
      3'b110:  next_tick = fc_tick;
      default: next_tick = pin_rise;
    endcase
  end

  // dividers restart with each start so the first period is whole
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fc_div <= {`TMR3_DIV_W{1'b0}};
      fs_div <= {`TMR3_DIV_W{1'b0}};
      tick   <= 1'b0;
    end
    else if (!run)
    begin
      fc_div <= {`TMR3_DIV_W{1'b0}};
      fs_div <= {`TMR3_DIV_W{1'b0}};
      tick   <= 1'b0;
    end
    else
    begin
      if (fc_tick)
        fc_div <= fc_nxt;
      if (fs_tick)
        fs_div <= fs_nxt;
      tick <= next_tick;
    end
  end
endmodule // tmr3_tick

// ==== core/tmr3_ctrl.v ====
// timer 3 control, source clock selection and 8/16-bit cascade with unit 4
// How it works
// - clock-select code picks fast (undivided or prescaled), slow (undivided or divided-by-8), or timer pin
// - start bit 0 stops and clears the counter; 1 starts counting
// - mode picks timer, divider output, pwm or cascade; top-bit codes reserved
// - mode, clock and preset are taken in the write that starts the timer
// - in cascade this unit's clock select feeds the 16-bit counter
// - in cascade the partner's start and preset bits govern
// - in cascade, partner with top mode bit counts this unit's overflow
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "tmr3_map.vh"
module tmr3_ctrl
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        fc_tick,
  input  wire        fs_tick,
  input  wire        timer_pin,
  output reg         timer3_out,
  output reg         overflow3,
  output reg         partner_tick
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_BAD  = 3'b100;

  reg  [7:0]  timer3_control;
  reg  [7:0]  timer3_period_compare;
  reg  [7:0]  timer3_pulse_width;
  reg  [7:0]  timer4_control;
  reg  [1:0]  sys_cfg;
  reg  [7:0]  count_lo;
  reg  [7:0]  count_hi;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg         pin_prev;
  reg         wr_ignored;
  reg  [31:0] rd_mux;
  reg  [31:0] read_word;
  wire        pin_sync;
  wire        pin_rise;
  wire        tick;
  wire        wr;
  wire        rd;
  wire        hit;

  wire [2:0] timer3_mode_field   = timer3_control[`TMR3_CTL_MODE_HI:`TMR3_CTL_MODE_LO];
  wire       timer3_start_bit    = timer3_control[`TMR3_CTL_START];
  wire [2:0] timer3_clock_select = timer3_control[`TMR3_CTL_CLK_HI:`TMR3_CTL_CLK_LO];
  wire       timer3_flipflop_preset = timer3_control[`TMR3_CTL_FF];
  wire [2:0] timer4_mode_field   = timer4_control[`TMR3_PTN_MODE_HI:`TMR3_PTN_MODE_LO];
  wire       timer4_start_bit    = timer4_control[`TMR3_PTN_START];
  wire       timer4_flipflop_preset = timer4_control[`TMR3_PTN_FF];
  wire       divider_stage_select = sys_cfg[`TMR3_SYS_DIVSEL];
  wire       low_speed_mode      = sys_cfg[`TMR3_SYS_LOWSPEED];

  wire cascade  = (timer3_mode_field == `TMR3_MODE_CASCADE);
  wire reserved = timer3_mode_field[2];
  wire start_eff = cascade ? timer4_start_bit : timer3_start_bit;
  wire ff_eff    = cascade ? timer4_flipflop_preset : timer3_flipflop_preset;
  wire run = (state == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: zero wait states, unmapped addresses answer with an error
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign pready  = 1'b1;
  // one decode per register, shared by the error flag and the write enables
  wire sel_ctl = (paddr == `TMR3_OFS_CONTROL);
  wire sel_per = (paddr == `TMR3_OFS_PERIOD);
  wire sel_pul = (paddr == `TMR3_OFS_PULSE);
  wire sel_ptn = (paddr == `TMR3_OFS_PARTNER);
  wire sel_sts = (paddr == `TMR3_OFS_STATUS);
  wire sel_sys = (paddr == `TMR3_OFS_SYSCFG);
  assign hit     = sel_ctl | sel_per | sel_pul | sel_ptn | sel_sts | sel_sys;
  assign pslverr = psel & penable & ~hit;

  always @*
  begin
    rd_mux = `TMR3_RST_WORD;
    if (rd)
    begin
      case (paddr)
        `TMR3_OFS_CONTROL: rd_mux = {24'h00_0000, timer3_control};
        `TMR3_OFS_PERIOD:  rd_mux = {24'h00_0000, timer3_period_compare};
        `TMR3_OFS_PULSE:   rd_mux = {24'h00_0000, timer3_pulse_width};
        `TMR3_OFS_PARTNER: rd_mux = {24'h00_0000, timer4_control};
        `TMR3_OFS_STATUS:  rd_mux = {8'h00, 5'b0_0000, wr_ignored, reserved, run,
                                     count_hi, count_lo};
        `TMR3_OFS_SYSCFG:  rd_mux = {30'h0000_0000, sys_cfg};
        default:           rd_mux = `TMR3_RST_WORD;
      endcase
    end
  end

  // read word captured in the setup cycle, so it stands through the access
  // cycle even if the counter moves; zero again once the access is taken
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_word <= `TMR3_RST_WORD;
    else if (psel & ~penable)
      read_word <= rd_mux;
    else
      read_word <= `TMR3_RST_WORD;
  end
  assign prdata = read_word;

  ////////////////////////////////////////////////////////////////////////////
  // register writes; config fields only latch while stopped or on the start write
  wire ctl_wr = wr & sel_ctl;
  wire ptn_wr = wr & sel_ptn;
  wire [2:0] new_mode = pwdata[`TMR3_CTL_MODE_HI:`TMR3_CTL_MODE_LO];
  wire pwm_any = (timer3_mode_field == `TMR3_MODE_PWM) |
                 (cascade & (timer4_mode_field == `TMR3_PMODE_PWM16));

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer3_control        <= `TMR3_RST_BYTE;
      timer3_period_compare <= `TMR3_RST_BYTE;
      timer3_pulse_width    <= `TMR3_RST_BYTE;
      timer4_control        <= `TMR3_RST_BYTE;
      sys_cfg               <= 2'b00;
      wr_ignored            <= 1'b0;
    end
    else
    begin
      if (ctl_wr)
      begin
        timer3_control[`TMR3_CTL_START] <= pwdata[`TMR3_CTL_START];
        // while running, only the start bit is taken; stop keeps the fields
        // run is checked too: in cascade the partner starts the pair
        if (!timer3_start_bit & !run)
        begin
          timer3_control[`TMR3_CTL_MODE_HI:`TMR3_CTL_MODE_LO] <= new_mode;
          timer3_control[`TMR3_CTL_CLK_HI:`TMR3_CTL_CLK_LO] <=
            pwdata[`TMR3_CTL_CLK_HI:`TMR3_CTL_CLK_LO];
          timer3_control[`TMR3_CTL_FF] <= pwdata[`TMR3_CTL_FF];
        end
      end
      if (ptn_wr)
        timer4_control <= pwdata[7:0];
      if (wr & sel_sys)
        sys_cfg <= pwdata[1:0];
      // guarded period and pulse writes; a refused write is flagged
      if (wr & sel_per)
      begin
        if (!run)
          timer3_period_compare <= pwdata[7:0];
        else
          wr_ignored <= 1'b1;
      end
      else if (wr & sel_pul)
      begin
        if (!run | pwm_any)
          timer3_pulse_width <= pwdata[7:0];
        else
          wr_ignored <= 1'b1;
      end
      else if (wr & sel_sts & pwdata[`TMR3_STS_REFUSED])
        wr_ignored <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input, tick generation
  tmr3_sync u_pin_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (timer_pin),
    .dout    (pin_sync)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_prev <= 1'b0;
    else
      pin_prev <= pin_sync;
  end
  assign pin_rise = pin_sync & ~pin_prev;

  // in cascade this unit's own select still drives the pair
  tmr3_tick u_tick
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (run),
    .clk_sel  (timer3_clock_select),
    .slow_src (divider_stage_select | low_speed_mode),
    .fc_tick  (fc_tick),
    .fs_tick  (fs_tick),
    .pin_rise (pin_rise),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // run state
  always @*
  begin
    case (state)
      ST_IDLE: next_state = reserved ? ST_BAD : (start_eff ? ST_RUN : ST_IDLE);
      ST_RUN:  next_state = start_eff ? ST_RUN : ST_IDLE;
      ST_BAD:  next_state = reserved ? ST_BAD : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting datapath for 8-bit modes and the 16-bit cascade
  wire match_lo = (count_lo == timer3_period_compare);
  wire upper16  = timer4_mode_field[2];
  wire lo_wrap  = tick & (count_lo == 8'hFF);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_lo     <= `TMR3_RST_BYTE;
      count_hi     <= `TMR3_RST_BYTE;
      timer3_out   <= 1'b0;
      overflow3    <= 1'b0;
      partner_tick <= 1'b0;
    end
    else if (!run)
    begin
      count_lo     <= `TMR3_RST_BYTE;
      count_hi     <= `TMR3_RST_BYTE;
      timer3_out   <= ff_eff;
      overflow3    <= 1'b0;
      partner_tick <= 1'b0;
    end
    else
    begin
      overflow3    <= 1'b0;
      partner_tick <= 1'b0;
      if (cascade)
      begin
        // upper byte counts the lower byte's overflow, not its own clock
        if (tick)
          count_lo <= count_lo + 8'h01;
        if (lo_wrap & upper16)
        begin
          partner_tick <= 1'b1;
          count_hi     <= count_hi + 8'h01;
          if (count_hi == 8'hFF)
            timer3_out <= ~timer3_out;
        end
      end
      else if (tick)
      begin
        case (timer3_mode_field)
          `TMR3_MODE_TIMER, `TMR3_MODE_PDO:
          begin
            if (match_lo)
            begin
              count_lo  <= `TMR3_RST_BYTE;
              overflow3 <= 1'b1;
              if (timer3_mode_field == `TMR3_MODE_PDO)
                timer3_out <= ~timer3_out;
            end
            else
              count_lo <= count_lo + 8'h01;
          end
          `TMR3_MODE_PWM:
          begin
            // output inverts on pulse-width match and returns at wrap
            count_lo <= count_lo + 8'h01;
            if (count_lo == timer3_pulse_width)
              timer3_out <= ~ff_eff;
            if (count_lo == 8'hFF)
            begin
              timer3_out <= ff_eff;
              overflow3  <= 1'b1;
            end
          end
          default: count_lo <= count_lo;
        endcase
      end
    end
  end
endmodule // tmr3_ctrl

// ==== verification/tmr3_ctrl_sva.sv ====
// concurrent checks on the ports of the timer 3 control block
`timescale 1ns/10ps
module tmr3_ctrl_sva
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        overflow3,
  input wire logic        partner_tick,
  input wire logic        timer3_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc  = psel && penable;
  wire ctlw = acc && pwrite && paddr == 12'h000;
  ////////////////////////////////////////////////////////////////////////////
  AST_READY_HIGH: assert property (pready)
    else $error("pready not high");
  AST_UNMAPPED_ERR: assert property (acc && paddr > 12'h014 |-> pslverr)
    else $error("no error on unmapped access");
  AST_ERR_ONLY_ACCESS: assert property (
    !acc || paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error outside unmapped access");
  AST_IDLE_RDATA: assert property (!psel |-> prdata == 32'h0000_0000)
    else $error("read data while idle");
  AST_BYTE_RDATA: assert property (
    psel && !pwrite && paddr <= 12'h008 |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  // one edge after a sampled low reset, so the start-up edge sees no race
  AST_RESET_OUTS: assert property (disable iff (1'b0)
    !presetn |=> !timer3_out && !overflow3 && !partner_tick)
    else $error("outputs not cleared in reset");
  // cascade stop is governed by the partner, so excluded; the run state
  // still lasts one edge after the write, so one late pulse is legal
  AST_STOP_QUIET: assert property (
    ctlw && !pwdata[3] && pwdata[2:0] != 3'b011 |=> ##2 !overflow3 [*6])
    else $error("overflow after stop");
  AST_PTICK_ONE: assert property (partner_tick |=> !partner_tick)
    else $error("carry pulse longer than one cycle");
  AST_RESERVED_IDLE: assert property (ctlw && pwdata[3] && pwdata[2] |=> !overflow3 [*8])
    else $error("reserved mode counts");
  ////////////////////////////////////////////////////////////////////////////
  COV_START: cover property (ctlw && pwdata[3]);
  COV_SLVERR: cover property (pslverr);
  COV_READ: cover property (acc && !pwrite && paddr == 12'h010);
  COV_OVF: cover property (overflow3);
  COV_PTICK: cover property (partner_tick);
endmodule // tmr3_ctrl_sva
bind tmr3_ctrl tmr3_ctrl_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .overflow3(overflow3), .partner_tick(partner_tick), .timer3_out(timer3_out));

// ==== verification/tb.sv ====
// register-level testbench for the timer 3 control block
`timescale 1ns/10ps
`include "tmr3_map.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, fc_tick, fs_tick, timer_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, serr, t3out, ovf, ptick;
  int          n_mismatch, checks_done, n_ovf, n_ptick;
  tmr3_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fc_tick(fc_tick), .fs_tick(fs_tick), .timer_pin(timer_pin),
    .timer3_out(t3out), .overflow3(ovf), .partner_tick(ptick));
  always #50 pclk = ~pclk;
  // one-cycle output pulses counted at the edge at which they stand
  always @(posedge pclk)
  begin
    if (ovf === 1'b1)
      n_ovf++;
    if (ptick === 1'b1)
      n_ptick++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks_done++;
      if (g !== e)
      begin
        $display("[ERR] %s expected %h seen %h", nm, e, g);
        n_mismatch++;
      end
    end
  endtask
  // request held until pready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
        @(posedge pclk);
        i++;
      end
      while (pready !== 1'b1 && i < 50);
      if (pready !== 1'b1)
      begin
        n_mismatch++;
        summarize;
      end
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rdat);
    end
  endtask
  // one-cycle event on fc (0), fs (1) or the timer pin (2)
  task pulse(input int sel, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (sel == 0) fc_tick <= 1'b1; else if (sel == 1) fs_tick <= 1'b1; else timer_pin <= 1'b1;
      @(posedge pclk);
      fc_tick <= 1'b0;
      fs_tick <= 1'b0;
      timer_pin <= 1'b0;
      @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    fc_tick = 0; fs_tick = 0; timer_pin = 0; n_mismatch = 0; checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) rd("reset value", 12'(4 * k), 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped error", 1, serr);
    apb(1'b1, `TMR3_OFS_PERIOD, 32'hFFFF_FFFF);
    rd("period byte", `TMR3_OFS_PERIOD, 32'h0000_00FF);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0068);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("run flag", 1, rdat[16]);
    pulse(0, 5);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("fast count", 5, rdat[7:0]);
    apb(1'b1, `TMR3_OFS_PERIOD, 32'h0000_0010);
    rd("period kept", `TMR3_OFS_PERIOD, 32'h0000_00FF);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("refused flag", 1, rdat[18]);
    apb(1'b1, `TMR3_OFS_STATUS, 32'h0004_0000);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_000A);
    rd("fields held", `TMR3_OFS_CONTROL, 32'h0000_0068);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0000);
    rd("stop keeps fields", `TMR3_OFS_CONTROL, 32'h0000_0060);
    rd("stop clears", `TMR3_OFS_STATUS, 32'h0000_0000);
    apb(1'b1, `TMR3_OFS_PULSE, 32'h0000_0033);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0068);
    apb(1'b1, `TMR3_OFS_PULSE, 32'h0000_0044);
    rd("pulse kept", `TMR3_OFS_PULSE, 32'h0000_0033);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0060);
    apb(1'b1, `TMR3_OFS_STATUS, 32'h0004_0000);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_006A);
    rd("start takes mode", `TMR3_OFS_CONTROL, 32'h0000_006A);
    apb(1'b1, `TMR3_OFS_PULSE, 32'h0000_0055);
    rd("pulse in pwm", `TMR3_OFS_PULSE, 32'h0000_0055);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0062);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0078);
    pulse(2, 3);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("pin count", 3, rdat[7:0]);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0070);
    apb(1'b1, `TMR3_OFS_SYSCFG, 32'h0000_0001);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0008);
    pulse(1, 16);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("slow over 8", 2, rdat[7:0]);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0000);
    apb(1'b1, `TMR3_OFS_SYSCFG, 32'h0000_0002);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0008);
    pulse(1, 8);
    rd("low-speed over 8", `TMR3_OFS_STATUS, 32'h0001_0001);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0000);
    apb(1'b1, `TMR3_OFS_PERIOD, 32'h0000_0002);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0069);
    pulse(0, 3);
    chk("divider output", 1, t3out);
    chk("period match pulses", 1, n_ovf);
    rd("match clears count", `TMR3_OFS_STATUS, 32'h0001_0000);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0061);
    rd("pdo stop clears", `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("stop loads preset", 0, t3out);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_000C);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("reserved no run", 32'h0002_0000, rdat & 32'h0003_0000);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0004);
    apb(1'b1, `TMR3_OFS_CONTROL, 32'h0000_0073);
    apb(1'b1, `TMR3_OFS_PARTNER, 32'h0000_000C);
    pulse(2, 3);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("cascade count", 3, rdat[15:0]);
    pulse(2, 253);
    apb(1'b0, `TMR3_OFS_STATUS, 32'h0000_0000);
    chk("upper byte count", 32'h0000_0100, rdat[15:0]);
    chk("lower byte carry", 1, n_ptick);
    apb(1'b1, `TMR3_OFS_PARTNER, 32'h0000_0004);
    pulse(0, 0);
    rd("partner stops", `TMR3_OFS_STATUS, 32'h0000_0000);
    summarize;
  end
endmodule // tb
